// ### jub_bridge.sv
// core logic behind the user test-port bridge: tuning, debug mux, rom read-back
// assumes bridge signals arrive unsynchronised; rom read is asynchronous
`default_nettype none
`timescale 1ns/10ps
module jub_bridge
    import jub_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic USER_SHIFT_CLOCK,
    input wire logic USER_SERIAL_IN,
    input wire logic SHIFT_DR_FLAG,
    input wire logic CAPTURE_DR_FLAG,
    input wire logic UPDATE_DATA_STATE_FLAG,
    input wire logic UPDATE_INSTRUCTION_STATE_FLAG,
    input wire logic [7:0] USER_INSTRUCTION_VALUE,
    input wire logic [DBG_N-1:0] DBG_NETS,
    input wire logic DBG_REG_EN,
    input wire logic DBG_EDGE_SEL,
    input wire logic CORE_ADDR_SEL,
    input wire logic [ROM_AW-1:0] CORE_ROM_ADDR,
    input wire logic [ROM_W-1:0] ROM_DATA,
    output logic USER_SERIAL_OUT,
    output logic USER_SERIAL_OUT_EN,
    output logic [7:0] CORE_INSTR,
    output logic [PARAM_W-1:0] PARAM_VALUE,
    output logic [ROM_AW-1:0] ROM_ADDR
);
    ////////////////////////////////////////////////////////////////////////////
    // input synchronisation and edge finding
    jub_tap_t raw;
    jub_tap_t tap;
    jub_tap_t prev_r;
    assign raw = '{tck: USER_SHIFT_CLOCK, tdi: USER_SERIAL_IN, shift: SHIFT_DR_FLAG,
                   capture: CAPTURE_DR_FLAG, update: UPDATE_DATA_STATE_FLAG,
                   upd_ir: UPDATE_INSTRUCTION_STATE_FLAG, ir: USER_INSTRUCTION_VALUE};

    jub_sync #(.W(TAP_W)) jub_sync_inst (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .din(raw),
        .dout(tap)
    );

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            prev_r <= '0;
        end else begin
            prev_r <= tap;
        end
    end

    wire logic tck_rise = tap.tck & ~prev_r.tck;
    wire logic tck_fall = ~tap.tck & prev_r.tck;
    wire logic cap_rise = tap.capture & ~prev_r.capture;
    wire logic upd_rise = tap.update & ~prev_r.update;
    wire logic uir_rise = tap.upd_ir & ~prev_r.upd_ir;
    wire logic shift_clk = tck_rise & tap.shift;

    ////////////////////////////////////////////////////////////////////////////
    // instruction seen by the core
    logic [7:0] ir_r;
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            ir_r <= IR_RESET;
        end else if (uir_rise) begin
            ir_r <= tap.ir;
        end
    end

    wire logic ir_user = (ir_r >= IR_USER_LO) && (ir_r <= IR_USER_HI);
    wire logic is_param = ir_r == IR_PARAM;
    wire logic is_addr = ir_r == IR_ROM_ADDR;
    wire logic is_rom = ir_r == IR_ROM_READ;
    wire logic is_rr = ir_r == IR_DBG_RR;
    wire logic is_dbg = (ir_r >= IR_DBG_BASE) && (ir_r <= IR_USER_HI);
    wire logic [7:0] dbg_off = ir_r - IR_DBG_BASE;

    ////////////////////////////////////////////////////////////////////////////
    // fine tuning: temporary shift register and live value
    logic [PARAM_W-1:0] tmp_r;
    logic [PARAM_W-1:0] tmp_nxt;
    logic [PARAM_W-1:0] param_r;
    assign tmp_nxt = (cap_rise && is_param) ? param_r :
                     (shift_clk && is_param) ? {tap.tdi, tmp_r[PARAM_W-1:1]} : tmp_r;
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            tmp_r <= '0;
            param_r <= PARAM_RESET;
        end else begin
            tmp_r <= tmp_nxt;
            if (upd_rise && is_param) begin
                param_r <= tmp_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // rom address and serializer
    logic [ROM_AW-1:0] atmp_r;
    logic [ROM_AW-1:0] addr_r;
    logic [ROM_W-1:0] rom_sr_r;
    logic [ROM_W-1:0] rom_sr_nxt;
    logic [ROM_AW-1:0] atmp_nxt;
    assign atmp_nxt = (cap_rise && is_addr) ? addr_r :
                      (shift_clk && is_addr) ? {tap.tdi, atmp_r[ROM_AW-1:1]} : atmp_r;
    // page selected by addr_r; rom answers asynchronously
    assign rom_sr_nxt = (cap_rise && is_rom) ? ROM_DATA :
                        (shift_clk && is_rom) ? {1'b0, rom_sr_r[ROM_W-1:1]} : rom_sr_r;
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            atmp_r <= '0;
            addr_r <= ROM_ADDR_RESET;
            rom_sr_r <= '0;
        end else begin
            atmp_r <= atmp_nxt;
            rom_sr_r <= rom_sr_nxt;
            if (CORE_ADDR_SEL) begin
                addr_r <= CORE_ROM_ADDR;
            end else if (upd_rise && is_addr) begin
                addr_r <= atmp_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // debug multiplexer
    logic [2:0] rr_r;
    logic dbg_r;
    wire logic dbg_edge = DBG_EDGE_SEL ? tck_fall : tck_rise;
    wire logic dbg_tick = ~DBG_REG_EN | dbg_edge;
    wire logic dbg_sel = is_rr ? DBG_NETS[rr_r] : DBG_NETS[dbg_off[6:0]];
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            rr_r <= '0;
            dbg_r <= 1'b0;
        end else begin
            if (dbg_tick && (is_dbg || is_rr)) begin
                dbg_r <= dbg_sel;
            end
            if (dbg_tick && is_rr) begin
                rr_r <= rr_r + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial output toward data-out
    logic tdo_r;
    logic tdo_en_r;
    wire logic tdo_nxt = is_param ? tmp_r[0] :
                         is_addr ? atmp_r[0] :
                         is_rom ? rom_sr_r[0] : dbg_r;
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            tdo_r <= 1'b0;
            tdo_en_r <= 1'b0;
        end else begin
            tdo_r <= tdo_nxt;
            tdo_en_r <= ir_user;
        end
    end

    assign USER_SERIAL_OUT = tdo_r;
    assign USER_SERIAL_OUT_EN = tdo_en_r;
    assign CORE_INSTR = ir_r;
    assign PARAM_VALUE = param_r;
    assign ROM_ADDR = addr_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);

    a_ir_hold: assert property (!uir_rise |=> $stable(ir_r))
        else $error("instruction changed without update");
    a_tmp_shift: assert property (!(tck_rise && tap.shift) && !cap_rise |=>
        $stable(tmp_r))
        else $error("temporary register moved outside shift");
    a_param_commit: assert property (upd_rise && is_param |=>
        PARAM_VALUE == $past(tmp_r))
        else $error("live value not committed on update");
    a_param_hold: assert property (!(upd_rise && is_param) |=> $stable(PARAM_VALUE))
        else $error("live value changed without commit");
    a_rom_load: assert property (cap_rise && is_rom |=> rom_sr_r == $past(ROM_DATA))
        else $error("rom page not loaded on capture");
    a_rom_shift: assert property (shift_clk && is_rom && !cap_rise |=>
        rom_sr_r == {1'b0, $past(rom_sr_r[ROM_W-1:1])})
        else $error("serializer did not advance");
    a_rom_addr: assert property (upd_rise && is_addr && !CORE_ADDR_SEL |=>
        ROM_ADDR == $past(atmp_r))
        else $error("host rom address not applied");
    a_dbg_pick: assert property (dbg_tick && is_dbg |=>
        dbg_r == $past(DBG_NETS[dbg_off[6:0]]))
        else $error("wrong debug net selected");
    a_rr_step: assert property (dbg_tick && is_rr |=> rr_r == $past(rr_r) + 3'h1)
        else $error("round robin did not step");
    a_tdo_range: assert property (ir_user |=> USER_SERIAL_OUT_EN)
        else $error("user output not enabled in user range");
    a_tdo_off: assert property (!ir_user |=> !USER_SERIAL_OUT_EN)
        else $error("user output enabled outside user range");

    c_param_commit: cover property (upd_rise && is_param ##1 PARAM_VALUE != $past(PARAM_VALUE));
    c_rom_read: cover property (cap_rise && is_rom ##[1:300] shift_clk);
    c_dbg_rr: cover property (is_rr && dbg_tick ##1 rr_r == 3'h0);
    c_addr_host: cover property (upd_rise && is_addr && !CORE_ADDR_SEL);
endmodule // jub_bridge
`default_nettype wire

// ### jub_bridge_test.sv
// self-checking bench for jub_bridge with the host model on the test port
// assumes a 200 MHz core clock; the rom is modelled as a pattern of its address
`default_nettype none
`timescale 1ns/10ps
module jub_bridge_test;
    import jub_pkg::*;
    logic clk, rst, tck, tdi, sh, cp, up, upir, out, oen, reg_en, edge_sel, asel;
    logic [7:0] ir, instr;
    logic [DBG_N-1:0] nets;
    logic [ROM_AW-1:0] caddr, raddr;
    logic [ROM_W-1:0] rom;
    logic [PARAM_W-1:0] pval;
    logic [127:0] q;
    int failures = 0;
    int checks_done = 0;
    // each page is its address with bit 3 set, repeated
    assign rom = {32{1'b1, raddr}};
    jub_host jub_host_inst (.clk(clk), .tdo(out), .tck(tck), .tdi(tdi), .shift(sh),
        .cap(cp), .upd(up), .updir(upir), .ir(ir));
    jub_bridge jub_bridge_inst (.CORE_CLK(clk), .SYS_RST(rst), .USER_SHIFT_CLOCK(tck),
        .USER_SERIAL_IN(tdi), .SHIFT_DR_FLAG(sh), .CAPTURE_DR_FLAG(cp),
        .UPDATE_DATA_STATE_FLAG(up), .UPDATE_INSTRUCTION_STATE_FLAG(upir), .USER_INSTRUCTION_VALUE(ir),
        .DBG_NETS(nets), .DBG_REG_EN(reg_en), .DBG_EDGE_SEL(edge_sel),
        .CORE_ADDR_SEL(asel), .CORE_ROM_ADDR(caddr), .ROM_DATA(rom),
        .USER_SERIAL_OUT(out), .USER_SERIAL_OUT_EN(oen), .CORE_INSTR(instr),
        .PARAM_VALUE(pval), .ROM_ADDR(raddr));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_tune;
        chk("reset param", pval, PARAM_RESET);
        chk("reset enable", oen, 1'h0);
        jub_host_inst.load_ir(IR_PARAM);
        chk("instr", instr, IR_PARAM);
        chk("enable", oen, 1'h1);
        jub_host_inst.dr(32'hA5C3_0F96, 32, 0, q);
        chk("param no update", pval, PARAM_RESET);
        jub_host_inst.dr(32'h1234_5678, 32, 1, q);
        chk("param", pval, 32'h1234_5678);
        jub_host_inst.dr(32'h0000_0000, 32, 0, q);
        chk("param readback", q, 32'h1234_5678);
        chk("param kept", pval, 32'h1234_5678);
        jub_host_inst.load_ir(IR_ROM_ADDR);
        jub_host_inst.dr(3'h5, 3, 1, q);
        chk("rom addr", raddr, 3'h5);
        chk("param held", pval, 32'h1234_5678);
        $display("done tuning");
    endtask
    task automatic t_rom;
        jub_host_inst.load_ir(IR_ROM_READ);
        jub_host_inst.dr('0, 128, 0, q);
        chk("rom page 5", q, {32{4'hD}});
        asel = 1'h1;
        caddr = 3'h2;
        repeat (10) @(negedge clk);
        chk("core addr", raddr, 3'h2);
        jub_host_inst.dr('0, 128, 0, q);
        chk("rom page 2", q, {32{4'hA}});
        asel = 1'h0;
        $display("done rom");
    endtask
    task automatic t_dbg;
        int ks[4] = '{0, 1, 5, 95};
        logic [7:0] bad[2] = '{8'h0F, 8'h80};
        foreach (ks[i]) begin
            jub_host_inst.load_ir(IR_DBG_BASE + 8'(ks[i]));
            chk("debug net", out, nets[ks[i]]);
        end
        chk("enable top", oen, 1'h1);
        foreach (bad[i]) begin
            jub_host_inst.load_ir(bad[i]);
            chk("enable off", oen, 1'h0);
        end
        $display("done debug");
    endtask
    task automatic t_edge;
        jub_host_inst.load_ir(IR_DBG_BASE + 8'h01);
        reg_en = 1'h1;
        nets[1] = 1'h1;
        jub_host_inst.pulse();
        chk("rise sample", out, 1'h1);
        nets[1] = 1'h0;
        jub_host_inst.half();
        chk("held", out, 1'h1);
        jub_host_inst.tck = 1'h1;
        jub_host_inst.half();
        chk("rise new", out, 1'h0);
        edge_sel = 1'h1;
        nets[1] = 1'h1;
        jub_host_inst.tck = 1'h0;
        jub_host_inst.half();
        chk("fall sample", out, 1'h1);
        reg_en = 1'h0;
        $display("done edge");
    endtask
    // round robin: one net per rising test-clock edge, wrapping after eight
    task automatic t_rr;
        logic [7:0] pat = 8'hB2;
        nets[7:0] = pat;
        edge_sel = 1'h0;
        reg_en = 1'h1;
        jub_host_inst.load_ir(IR_DBG_RR);
        for (int k = 0; k < 9; k++) begin
            jub_host_inst.pulse();
            chk("round robin", out, pat[k % 8]);
        end
        reg_en = 1'h0;
        $display("done round robin");
    endtask
    // mid-run reset: live values fall back to defaults and must be loaded again
    task automatic t_reset;
        rst = 1'h1;
        repeat (5) @(negedge clk);
        rst = 1'h0;
        repeat (2) @(negedge clk);
        chk("reset instr", instr, IR_RESET);
        chk("reset live", pval, PARAM_RESET);
        chk("reset addr", raddr, ROM_ADDR_RESET);
        chk("reset off", oen, 1'h0);
        repeat (10) @(negedge clk);
        chk("instr no update", instr, IR_RESET);
        jub_host_inst.load_ir(IR_PARAM);
        jub_host_inst.dr(32'h5A3C_96E1, 32, 1, q);
        chk("param reloaded", pval, 32'h5A3C_96E1);
        $display("done reset");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #200000;
        failures++;
        $display("watchdog expired");
        stop_test();
    end
    initial begin
        rst = 1;
        nets = {1'b1, 90'h0, 5'h01} | 96'h20;
        {reg_en, edge_sel, asel} = 3'h0;
        caddr = 3'h0;
        repeat (5) @(negedge clk);
        rst = 0;
        repeat (10) @(negedge clk);
        t_tune();
        t_rom();
        t_dbg();
        t_edge();
        t_rr();
        t_reset();
        stop_test();
    end
endmodule // jub_bridge_test
`default_nettype wire

// ### jub_host.sv
// test-port host model: drives the bridge flags, test clock, serial data
// assumes the core clock copy is given for pacing; test clock half period 80 ns
`default_nettype none
`timescale 1ns/10ps
module jub_host (
    input wire logic clk,
    input wire logic tdo,
    output logic tck,
    output logic tdi,
    output logic shift,
    output logic cap,
    output logic upd,
    output logic updir,
    output logic [7:0] ir
);
    initial begin
        {tck, tdi, shift, cap, upd, updir} = 6'h00;
        ir = 8'h00;
    end
    task automatic half;
        repeat (16) @(negedge clk);
    endtask
    task automatic pulse;
        tck = 1;
        half();
        tck = 0;
        half();
    endtask
    // parallel instruction load with one update pulse, no shifting, before any data scan
    task automatic load_ir(input logic [7:0] v);
        ir = v;
        half();
        updir = 1;
        pulse();
        updir = 0;
        half();
    endtask
    // data scan: capture, n shifts lsb first, optional update; tdo taken before each rise
    task automatic dr(input logic [127:0] d, input int n, input bit commit,
                      output logic [127:0] q);
        q = '0;
        cap = 1;
        pulse();
        cap = 0;
        shift = 1;
        for (int i = 0; i < n; i++) begin
            tdi = d[i];
            half();
            q[i] = tdo;
            tck = 1;
            half();
            tck = 0;
        end
        shift = 0;
        tdi = ~tdi;
        if (commit) begin
            upd = 1;
            pulse();
            upd = 0;
        end
        half();
    endtask
endmodule // jub_host
`default_nettype wire

// ### jub_pkg.sv
// constants and carrier types for the user test-port data bridge
// assumes a core clock far faster than the test clock copy
`default_nettype none
package jub_pkg;
    localparam int PARAM_W = 32;
    localparam int ROM_W = 128;
    localparam int ROM_AW = 3;
    localparam int DBG_N = 96;
    localparam int RR_N = 8;
    localparam logic [7:0] IR_USER_LO = 8'h10;
    localparam logic [7:0] IR_USER_HI = 8'h7F;
    localparam logic [7:0] IR_PARAM = 8'h10;
    localparam logic [7:0] IR_ROM_ADDR = 8'h11;
    localparam logic [7:0] IR_ROM_READ = 8'h12;
    localparam logic [7:0] IR_DBG_RR = 8'h13;
    localparam logic [7:0] IR_DBG_BASE = 8'h20;
    localparam logic [7:0] IR_RESET = 8'h00;
    localparam logic [PARAM_W-1:0] PARAM_RESET = 32'h0000_0000;
    localparam logic [ROM_AW-1:0] ROM_ADDR_RESET = 3'h0;
    localparam int TAP_W = 14;

    // test-port bridge signals as seen by the core
    typedef struct packed {
        logic tck;
        logic tdi;
        logic shift;
        logic capture;
        logic update;
        logic upd_ir;
        logic [7:0] ir;
    } jub_tap_t;
endpackage
`default_nettype wire

// ### jub_sync.sv
// three-stage input synchroniser with agreement filter, one per bit
// assumes inputs come from outside the core clock domain
`default_nettype none
`timescale 1ns/10ps
module jub_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1_r;
            logic s2_r;
            logic s3_r;
            logic q_r;
            always_ff @(posedge clk) begin
                if (rst) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                    q_r <= 1'b0;
                end else begin
                    s1_r <= din[i];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    // a change counts once stages two and three agree
                    if (s2_r == s3_r) begin
                        q_r <= s3_r;
                    end
                end
            end
            assign dout[i] = q_r;
        end
    endgenerate
endmodule // jub_sync
`default_nettype wire
